// ==== design/arsc_pkg.sv ====
package arsc_pkg;

    // ****************************************************************
    // register indices (byte address is four times the index)
    // ****************************************************************
    localparam logic [5:0] IDX_CFG_ONE = 6'h00;
    localparam logic [5:0] IDX_CFG_TWO = 6'h01;
    localparam logic [5:0] IDX_CFG_THREE = 6'h02;
    localparam logic [5:0] IDX_STATUS = 6'h03;
    localparam logic [5:0] IDX_RES_HIGH = 6'h04;
    localparam logic [5:0] IDX_RES_LOW = 6'h05;
    localparam logic [5:0] IDX_TRIG_FIRST = 6'h06;
    localparam logic [5:0] IDX_TRIG_SECOND = 6'h07;
    localparam logic [5:0] IDX_TRIG_THIRD = 6'h08;
    localparam logic [5:0] IDX_TRIG_FOURTH = 6'h09;
    localparam logic [5:0] IDX_ACTIVITY = 6'h0A;
    localparam logic [5:0] IDX_TEMP_CALIB = 6'h0B;
    localparam logic [5:0] IDX_REF_CALIB = 6'h0C;

    // ****************************************************************
    // reset values
    // ****************************************************************
    localparam logic [7:0] RST_CFG_ONE = 8'h00;
    localparam logic [7:0] RST_CFG_TWO = 8'h00;
    localparam logic [7:0] RST_CFG_THREE = 8'h1F;
    localparam logic [7:0] RST_BYTE = 8'h00;

    // ****************************************************************
    // field positions
    // ****************************************************************
    localparam int POS_POWER_ON = 0;
    localparam int POS_START = 1;
    localparam int POS_RES_LSB = 5;
    localparam int POS_FIELD_A_LSB = 0;
    localparam int POS_FIELD_B_LSB = 5;
    localparam int POS_EOC = 0;
    localparam int POS_TEMP_EN = 5;
    localparam int POS_REF_EN = 4;
    localparam int POS_BUSY = 0;
    localparam int POS_SAMPLING = 1;

    // ****************************************************************
    // resolution codes, channel groups, calibration high nibbles
    // ****************************************************************
    localparam logic [1:0] RES_12 = 2'h0;
    localparam logic [1:0] RES_10 = 2'h1;
    localparam logic [1:0] RES_8 = 2'h2;
    localparam logic [1:0] RES_6 = 2'h3;
    localparam logic [4:0] FIRST_HIGH_GROUP_CH = 5'h18;
    localparam logic [3:0] TEMP_CALIB_HIGH = 4'h3;
    localparam logic [3:0] REF_CALIB_HIGH = 4'h6;

    // ****************************************************************
    // timing
    // ****************************************************************
    localparam logic [8:0] SAMPLE_CYCLES [8] = '{9'h004, 9'h009, 9'h010, 9'h018,
                                                9'h030, 9'h060, 9'h0C0, 9'h180};
    localparam int CLK_PERIOD_NS = 20;
    localparam int TEMP_SAMPLE_NS = 10000;
    localparam int TEMP_SAMPLE_CYCLES = (TEMP_SAMPLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic [1:0] {CS_IDLE, CS_SAMPLE, CS_CONVERT} arsc_conv_state_t;

endpackage

// ==== design/arsc_align.sv ====
`timescale 1ns/1ns
`default_nettype none
module arsc_align
    import arsc_pkg::*;
(
    input wire logic [1:0] res,
    input wire logic [11:0] raw,
    output logic [7:0] high_byte,
    output logic [7:0] low_byte
);

    // the core delivers top-aligned bits; shift right by two per step down
    always_comb
    begin
        case (res)
            RES_12:
            begin
                high_byte = {4'h0, raw[11:8]};
                low_byte = raw[7:0];
            end
            RES_10:
            begin
                high_byte = {6'h00, raw[11:10]};
                low_byte = raw[9:2];
            end
            RES_8:
            begin
                high_byte = 8'h00;
                low_byte = raw[11:4];
            end
            default:
            begin
                high_byte = 8'h00;
                low_byte = {2'h0, raw[11:6]};
            end
        endcase
    end

endmodule
`default_nettype wire

// ==== design/arsc_sample_timer.sv ====
`timescale 1ns/1ns
`default_nettype none
module arsc_sample_timer
    import arsc_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic load,
    input wire logic [2:0] code,
    output logic expire
);

    logic [8:0] count_q;
    logic running_q;

    // expire marks the last sampling cycle, so sampling lasts exactly the count
    assign expire = running_q && (count_q == 9'h001);

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            count_q <= 9'h000;
            running_q <= 1'b0;
        end
        else if (load)
        begin
            count_q <= SAMPLE_CYCLES[code];
            running_q <= 1'b1;
        end
        else if (running_q)
        begin
            count_q <= count_q - 9'h001;
            running_q <= !expire;
        end
    end

endmodule
`default_nettype wire

// ==== design/arsc_top.sv ====
// Summary of operation
// - 12-bit: high byte bits 3:0, low byte rest
// - right aligned result for every resolution
// - field a for channels 0-23, b above
// - codes select 4 to 384 sampling cycles
// - schmitt disables for 25 or 28 pins
// - routed pin: comparator schmitt enable wins
// - temp sensor connected only while enabled
// - internal reference on only while enabled
// - temp calibration high nibble is 0x3
// - reference calibration high nibble is 0x6
// - resolution codes 00..11 give 12..6 bits
// - high byte read snapshots low byte
// - field a at bits 2:0 of config two
// - field b at bits 7:5 of config three
//
// Decided for this implementation: the address map and the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module arsc_top
    import arsc_pkg::*;
#(
    parameter int NUM_SCHMITT = 28
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [4:0] conv_channel,
    input wire logic ext_start,
    input wire logic core_result_valid,
    input wire logic [11:0] core_result,
    input wire logic [7:0] temp_calib_byte,
    input wire logic [7:0] ref_calib_byte,
    input wire logic [27:0] routing_io_control_mask,
    input wire logic comparator_schmitt_enable,
    output logic converter_power_on,
    output logic core_sample,
    output logic core_convert,
    output logic [1:0] core_resolution,
    output logic temp_sensor_on,
    output logic internal_ref_on,
    output logic [27:0] schmitt_disable,
    output logic conv_busy
);

    // ****************************************************************
    // register state
    // ****************************************************************
    logic [7:0] cfg_one_q;
    logic [7:0] cfg_two_q;
    logic [7:0] cfg_three_q;
    logic start_q;
    logic eoc_q;
    logic [7:0] result_high_byte_q;
    logic [7:0] result_low_byte_q;
    logic [7:0] shadow_q;
    logic shadow_valid_q;
    logic temp_en_q;
    logic ref_en_q;
    logic [27:0] sch_q;
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;
    arsc_conv_state_t state_q;
    logic [1:0] res_conv_q;
    logic [2:0] smp_code;
    logic core_sample_q;
    logic core_convert_q;
    logic [27:0] sch_d;
    logic [27:0] sch_out_q;
    logic temp_on_q;
    logic ref_on_q;
    logic power_q;
    logic busy_q;

    // ****************************************************************
    // bus decode
    // ****************************************************************
    logic [5:0] idx;
    logic setup;
    logic done;
    logic wr;
    logic rd;
    logic hit;
    logic [7:0] rd_d;

    assign idx = paddr[7:2];
    assign setup = psel && !penable;
    assign done = psel && penable && pready_q;
    assign wr = done && pwrite;
    assign rd = done && !pwrite;

    always_comb
    begin
        hit = 1'b1;
        rd_d = 8'h00;
        case (idx)
            IDX_CFG_ONE:
            begin
                rd_d = cfg_one_q;
                rd_d[POS_START] = start_q;
            end
            IDX_CFG_TWO: rd_d = cfg_two_q;
            IDX_CFG_THREE: rd_d = cfg_three_q;
            IDX_STATUS: rd_d[POS_EOC] = eoc_q;
            IDX_RES_HIGH: rd_d = result_high_byte_q;
            IDX_RES_LOW: rd_d = shadow_valid_q ? shadow_q : result_low_byte_q;
            IDX_TRIG_FIRST:
            begin
                rd_d[POS_TEMP_EN] = temp_en_q;
                rd_d[POS_REF_EN] = ref_en_q;
                rd_d[3:0] = sch_q[27:24];
            end
            IDX_TRIG_SECOND: rd_d = sch_q[23:16];
            IDX_TRIG_THIRD: rd_d = sch_q[15:8];
            IDX_TRIG_FOURTH: rd_d = sch_q[7:0];
            IDX_ACTIVITY:
            begin
                rd_d[POS_BUSY] = (state_q != CS_IDLE);
                rd_d[POS_SAMPLING] = core_sample_q;
            end
            IDX_TEMP_CALIB: rd_d = temp_calib_byte;
            IDX_REF_CALIB: rd_d = ref_calib_byte;
            default: hit = 1'b0;
        endcase
    end

    // ****************************************************************
    // apb answer: data latched at setup, ready in the first access cycle
    // ****************************************************************
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            prdata_q <= 32'h0000_0000;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end
        else
        begin
            pready_q <= setup;
            pslverr_q <= setup && !hit;
            if (setup)
            begin
                prdata_q <= {24'h00_0000, rd_d};
                if (idx == IDX_TEMP_CALIB)
                begin
                    prdata_q <= {20'h0_0000, TEMP_CALIB_HIGH, temp_calib_byte};
                end
                if (idx == IDX_REF_CALIB)
                begin
                    prdata_q <= {20'h0_0000, REF_CALIB_HIGH, ref_calib_byte};
                end
            end
        end
    end

    // ****************************************************************
    // configuration registers
    // ****************************************************************
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            cfg_one_q <= RST_CFG_ONE;
            cfg_two_q <= RST_CFG_TWO;
            cfg_three_q <= RST_CFG_THREE;
        end
        else if (wr)
        begin
            if (idx == IDX_CFG_ONE)
            begin
                cfg_one_q <= pwdata[7:0];
            end
            if (idx == IDX_CFG_TWO)
            begin
                cfg_two_q <= pwdata[7:0];
            end
            if (idx == IDX_CFG_THREE)
            begin
                cfg_three_q <= pwdata[7:0];
            end
        end
    end

    // start is a one-cycle request; it is ignored while a conversion runs
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            start_q <= 1'b0;
        end
        else
        begin
            start_q <= wr && (idx == IDX_CFG_ONE) && pwdata[POS_START];
        end
    end

    // ****************************************************************
    // analog channel and schmitt controls
    // ****************************************************************
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            temp_en_q <= 1'b0;
            ref_en_q <= 1'b0;
            sch_q <= 28'h000_0000;
        end
        else if (wr)
        begin
            case (idx)
                IDX_TRIG_FIRST:
                begin
                    temp_en_q <= pwdata[POS_TEMP_EN];
                    ref_en_q <= pwdata[POS_REF_EN];
                    sch_q[27:24] <= pwdata[3:0];
                end
                IDX_TRIG_SECOND: sch_q[23:16] <= pwdata[7:0];
                IDX_TRIG_THIRD: sch_q[15:8] <= pwdata[7:0];
                IDX_TRIG_FOURTH: sch_q[7:0] <= pwdata[7:0];
                default: sch_q <= sch_q;
            endcase
        end
    end

    // pins beyond the part's count have no control and drive zero, but their register bits read back as written;
    // the shared-comparator disable is software's job, this only arbitrates
    for (genvar i = 0; i < 28; i++)
    begin : g_sch
        if (i < NUM_SCHMITT)
        begin : g_pin
            assign sch_d[i] = routing_io_control_mask[i] ? !comparator_schmitt_enable
                                                          : sch_q[i];
        end
        else
        begin : g_none
            assign sch_d[i] = 1'b0;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            sch_out_q <= 28'h000_0000;
            temp_on_q <= 1'b0;
            ref_on_q <= 1'b0;
            power_q <= 1'b0;
        end
        else
        begin
            sch_out_q <= sch_d;
            temp_on_q <= temp_en_q;
            ref_on_q <= ref_en_q;
            power_q <= cfg_one_q[POS_POWER_ON];
        end
    end

    // ****************************************************************
    // conversion sequence
    // ****************************************************************
    logic go;
    logic smp_expire;
    logic [7:0] fmt_high;
    logic [7:0] fmt_low;

    assign go = (state_q == CS_IDLE) && cfg_one_q[POS_POWER_ON] && (start_q || ext_start);
    assign smp_code = (conv_channel >= FIRST_HIGH_GROUP_CH)
                    ? cfg_three_q[POS_FIELD_B_LSB +: 3]
                    : cfg_two_q[POS_FIELD_A_LSB +: 3];

    arsc_sample_timer u_timer (
        .clk(clk),
        .rst(rst),
        .load(go),
        .code(smp_code),
        .expire(smp_expire)
    );

    arsc_align u_align (
        .res(res_conv_q),
        .raw(core_result),
        .high_byte(fmt_high),
        .low_byte(fmt_low)
    );

    always_ff @(posedge clk)
    begin
        if (rst || !cfg_one_q[POS_POWER_ON])
        begin
            state_q <= CS_IDLE;
            core_sample_q <= 1'b0;
            core_convert_q <= 1'b0;
            res_conv_q <= RES_12;
            busy_q <= 1'b0;
        end
        else
        begin
            case (state_q)
                CS_IDLE:
                begin
                    if (go)
                    begin
                        state_q <= CS_SAMPLE;
                        core_sample_q <= 1'b1;
                        busy_q <= 1'b1;
                        res_conv_q <= cfg_one_q[POS_RES_LSB +: 2];
                    end
                end
                CS_SAMPLE:
                begin
                    if (smp_expire)
                    begin
                        state_q <= CS_CONVERT;
                        core_sample_q <= 1'b0;
                        core_convert_q <= 1'b1;
                    end
                end
                CS_CONVERT:
                begin
                    if (core_result_valid)
                    begin
                        state_q <= CS_IDLE;
                        core_convert_q <= 1'b0;
                        busy_q <= 1'b0;
                    end
                end
                default: state_q <= CS_IDLE;
            endcase
        end
    end

    // ****************************************************************
    // result bytes, shadow and end-of-conversion flag
    // ****************************************************************
    logic result_load;

    assign result_load = (state_q == CS_CONVERT) && core_result_valid && cfg_one_q[POS_POWER_ON];

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            result_high_byte_q <= RST_BYTE;
            result_low_byte_q <= RST_BYTE;
        end
        else if (result_load)
        begin
            result_high_byte_q <= fmt_high;
            result_low_byte_q <= fmt_low;
        end
    end

    // the snapshot is taken at setup with the high byte data so both halves agree
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            shadow_q <= RST_BYTE;
            shadow_valid_q <= 1'b0;
        end
        else
        begin
            if (setup && !pwrite && (idx == IDX_RES_HIGH))
            begin
                shadow_q <= result_low_byte_q;
            end
            if (rd && (idx == IDX_RES_HIGH))
            begin
                shadow_valid_q <= 1'b1;
            end
            else if (rd && (idx == IDX_RES_LOW))
            begin
                shadow_valid_q <= 1'b0;
            end
        end
    end

    // a new result in the same cycle as a clear keeps the flag set
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            eoc_q <= 1'b0;
        end
        else if (result_load)
        begin
            eoc_q <= 1'b1;
        end
        else if (!cfg_one_q[POS_POWER_ON] || (rd && (idx == IDX_RES_LOW))
                 || (wr && (idx == IDX_STATUS) && !pwdata[POS_EOC]))
        begin
            eoc_q <= 1'b0;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign converter_power_on = power_q;
    assign core_sample = core_sample_q;
    assign core_convert = core_convert_q;
    assign core_resolution = res_conv_q;
    assign temp_sensor_on = temp_on_q;
    assign internal_ref_on = ref_on_q;
    assign schmitt_disable = sch_out_q;
    assign conv_busy = busy_q;

endmodule
`default_nettype wire

// ==== tb/arsc_core_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module arsc_core_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic core_convert,
    input wire logic [11:0] value,
    input wire logic [3:0] lat,
    output logic core_result_valid,
    output logic [11:0] core_result
);
    logic [3:0] cnt_q;

    // ****************************************************************
    // analog core: answers lat + 1 cycles into the convert phase
    // ****************************************************************
    // the result lines toggle when not valid, so a stale value never passes
    always_ff @(posedge clk)
    begin
        if (rst || !core_convert || core_result_valid)
        begin
            cnt_q <= 4'h0;
            core_result_valid <= 1'b0;
            core_result <= rst ? 12'h5A5 : ~core_result;
        end
        else if (cnt_q == lat)
        begin
            core_result_valid <= 1'b1;
            core_result <= value;
        end
        else
        begin
            cnt_q <= cnt_q + 4'h1;
            core_result <= ~core_result;
        end
    end
endmodule
`default_nettype wire

// ==== tb/arsc_checker.sv ====
`timescale 1ns/1ns
`default_nettype none
module arsc_checker #(
    parameter int NUM_SCHMITT = 28
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [7:0] temp_calib_byte,
    input wire logic [7:0] ref_calib_byte,
    input wire logic [27:0] routing_io_control_mask,
    input wire logic comparator_schmitt_enable,
    input wire logic core_sample,
    input wire logic core_convert,
    input wire logic temp_sensor_on,
    input wire logic internal_ref_on,
    input wire logic [27:0] schmitt_disable
);
    localparam logic [27:0] LIM = (28'h1 << NUM_SCHMITT) - 28'h1;
    logic [8:0] len_q;
    logic wr_trig;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // ****************************************************************
    // helpers
    // ****************************************************************
    assign wr_trig = psel && penable && pready && pwrite && paddr == 8'h18;
    always_ff @(posedge clk)
    begin
        len_q <= (rst || !core_sample) ? 9'h0 : len_q + 9'h1;
    end

    a_sample_len_legal: assert property ($fell(core_sample) |->
        len_q inside {9'h004, 9'h009, 9'h010, 9'h018, 9'h030, 9'h060, 9'h0C0, 9'h180})
        else $error("sampling phase has an illegal length");
    a_sample_min: assert property ($rose(core_sample) |-> core_sample [*4])
        else $error("sampling phase shorter than four cycles");
    a_convert_follows: assert property ($fell(core_sample) |-> core_convert)
        else $error("bit conversion did not follow sampling");
    a_temp_follow: assert property ($changed(temp_sensor_on) |->
        $past(wr_trig) || $past(wr_trig, 2))
        else $error("temperature sensor switched without a write");
    a_ref_follow: assert property ($changed(internal_ref_on) |->
        $past(wr_trig) || $past(wr_trig, 2))
        else $error("internal reference switched without a write");
    a_schmitt_override: assert property (!$past(rst) |-> ((schmitt_disable ^
        {28{!$past(comparator_schmitt_enable)}}) & $past(routing_io_control_mask) & LIM) == 28'h0)
        else $error("routed pin ignores comparator schmitt enable");
    a_schmitt_width: assert property ((schmitt_disable & ~LIM) == 28'h0)
        else $error("schmitt disable beyond the pin count");
    a_high_nibble: assert property (pready && !pwrite && paddr == 8'h10 |->
        prdata[31:4] == 28'h0)
        else $error("high result byte upper bits not zero");
    a_temp_calib: assert property (pready && !pwrite && paddr == 8'h2C |->
        prdata == {20'h0, 4'h3, temp_calib_byte})
        else $error("temperature calibration value wrong");
    a_ref_calib: assert property (pready && !pwrite && paddr == 8'h30 |->
        prdata == {20'h0, 4'h6, ref_calib_byte})
        else $error("reference calibration value wrong");
    a_ready_one_cycle: assert property (psel && !penable |=> pready ##1 !pready)
        else $error("ready not exactly one cycle after setup");
    a_unmapped_err: assert property (pready && paddr[7:2] > 6'h0C |-> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
endmodule

bind arsc_top arsc_checker #(.NUM_SCHMITT(NUM_SCHMITT)) chk (.clk, .rst, .psel, .penable,
    .pwrite, .paddr, .prdata, .pready, .pslverr, .temp_calib_byte, .ref_calib_byte,
    .routing_io_control_mask, .comparator_schmitt_enable, .core_sample, .core_convert,
    .temp_sensor_on, .internal_ref_on, .schmitt_disable);
`default_nettype wire

// ==== tb/tb_adc_result_align_sampling_ctrl.sv ====
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin n_fail++; \
    $display("wrong value %s exp %h got %h", nm, ex, got); end end
module tb_adc_result_align_sampling_ctrl
    import arsc_pkg::*;
;
    logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00, temp_calib_byte = 8'h5C, ref_calib_byte = 8'hA3;
    logic [31:0] pwdata = 32'h0, rd, r, m, seed = 32'h39B3;
    logic [4:0] conv_channel = 5'h00;
    logic ext_start = 1'b0, comparator_schmitt_enable = 1'b0, err;
    logic [27:0] routing_io_control_mask = 28'h0, e;
    logic [11:0] raw_v = 12'h0;
    logic [3:0] lat_v = 4'h0;
    logic [15:0] ex;
    logic [31:0] prdata;
    logic [27:0] schmitt_disable;
    logic [11:0] core_result;
    logic [1:0] core_resolution;
    logic pready, pslverr, converter_power_on, core_sample, core_convert;
    logic temp_sensor_on, internal_ref_on, conv_busy, core_result_valid;
    int n_fail = 0, num_checks = 0;

    arsc_top #(.NUM_SCHMITT(25)) uut (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .conv_channel, .ext_start, .core_result_valid,
        .core_result, .temp_calib_byte, .ref_calib_byte, .routing_io_control_mask,
        .comparator_schmitt_enable, .converter_power_on, .core_sample, .core_convert,
        .core_resolution, .temp_sensor_on, .internal_ref_on, .schmitt_disable, .conv_busy);
    arsc_core_model model (.clk, .rst, .core_convert, .value(raw_v), .lat(lat_v),
        .core_result_valid, .core_result);

    always #10 clk = ~clk;

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic stop_test();
        if (n_fail == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // ****************************************************************
    // bus and conversion tasks
    // ****************************************************************
    // one idle cycle after each transfer so no strobe is set twice at an edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1)
            @(posedge clk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    task automatic convert(input logic [4:0] ch, input logic [1:0] res, input logic [2:0] ca,
        input logic [2:0] cb, input logic [11:0] raw, input logic ext);
        logic [8:0] n;
        n = 9'h0;
        apb(1'b1, 8'h04, {29'h0, ca});
        apb(1'b1, 8'h08, {24'h0, cb, 5'h1F});
        conv_channel <= ch;
        raw_v <= raw;
        lat_v <= 4'(xs());
        apb(1'b1, 8'h00, {25'h0, res, 3'h0, ~ext, 1'b1});
        if (ext)
        begin
            ext_start <= 1'b1;
            @(posedge clk);
            ext_start <= 1'b0;
        end
        while (core_sample !== 1'b1)
            @(posedge clk);
        `CHK("resolution", res, core_resolution)
        `CHK("power on", 1'b1, converter_power_on)
        `CHK("busy", 1'b1, conv_busy)
        while (core_sample === 1'b1)
        begin
            n++;
            @(posedge clk);
        end
        m = {23'h0, SAMPLE_CYCLES[ch >= FIRST_HIGH_GROUP_CH ? cb : ca]};
        `CHK("sample cycles", m[8:0], n)
        while (conv_busy === 1'b1)
            @(posedge clk);
    endtask

    initial
    begin
        #1000000;
        n_fail++;
        stop_test();
    end

    initial
    begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        apb(1'b0, 8'h08, 32'h0);
        `CHK("config three reset", RST_CFG_THREE, rd)
        apb(1'b0, 8'h10, 32'h0);
        `CHK("high byte reset", RST_BYTE, rd)
        `CHK("power off", 1'b0, converter_power_on)
        apb(1'b1, 8'h3C, 32'hFF);
        `CHK("unmapped error", 1'b1, err)
        apb(1'b0, 8'h2C, 32'h0);
        `CHK("temp calib", {20'h0, 4'h3, temp_calib_byte}, rd)
        apb(1'b0, 8'h30, 32'h0);
        `CHK("ref calib", {20'h0, 4'h6, ref_calib_byte}, rd)
        apb(1'b1, 8'h18, 32'h20);
        for (int i = 0; i < 8; i++)
        begin
            r = xs();
            convert((i == 2) ? 5'h1D : 5'(r[20:16] % 30), i[1:0], i[2:0], ~i[2:0], r[11:0], i[0]);
            ex = {4'h0, r[11:0]} >> (2 * i[1:0]);
            apb(1'b0, 8'h10, 32'h0);
            `CHK("high byte", {24'h0, ex[15:8]}, rd)
            apb(1'b0, 8'h14, 32'h0);
            `CHK("low byte", {24'h0, ex[7:0]}, rd)
        end
        // a fresh result between the two reads must not reach the low byte
        apb(1'b0, 8'h10, 32'h0);
        r = xs();
        convert(5'h03, RES_12, 3'h0, 3'h0, ~r[11:0], 1'b0);
        apb(1'b0, 8'h0C, 32'h0);
        `CHK("eoc set", 32'h1, rd)
        apb(1'b0, 8'h14, 32'h0);
        `CHK("shadow low byte", {24'h0, ex[7:0]}, rd)
        apb(1'b0, 8'h0C, 32'h0);
        `CHK("eoc cleared", 32'h0, rd)
        for (int i = 0; i < 4; i++)
        begin
            r = xs();
            m = (i == 0) ? 32'h0 : (i == 1) ? 32'hFFFFFFFF : xs();
            routing_io_control_mask <= m[27:0];
            comparator_schmitt_enable <= r[0];
            apb(1'b1, 8'h18, {26'h0, r[5:0]});
            apb(1'b1, 8'h1C, {24'h0, r[15:8]});
            apb(1'b1, 8'h20, {24'h0, r[23:16]});
            apb(1'b1, 8'h24, {24'h0, r[31:24]});
            repeat (2) @(posedge clk);
            e = {r[3:0], r[15:8], r[23:16], r[31:24]};
            e = (e & ~m[27:0]) | (m[27:0] & {28{~r[0]}});
            `CHK("schmitt disable", e & 28'h1FFFFFF, schmitt_disable)
            `CHK("temp sensor on", r[5], temp_sensor_on)
            `CHK("reference on", r[4], internal_ref_on)
        end
        stop_test();
    end
endmodule
`default_nettype wire
